// ---- rtl/enc_div_pkg.sv ----
// constants and types for error-counter clear and encoder pulse divider
// Contract
// - clear input high halts loop; error counter is cleared as the clear mode selects
// - clear-mode bit picks level clearing or one-shot rising-edge clearing
// - mode 0: counter held at zero while input high, nothing accumulates
// - mode 1: clear once on rising edge, then accumulate while high
// - divided phase a, b, c outputs as differential pairs
// - emit programmed pulses per revolution on phases a and b
// - incremental 2048 ppr: ratio limited to 16..2048
// - absolute 1024 ppr: ratio limited to 16..1024
// - encoder type 0 incremental, 1 absolute; sets assumed pulses/rev
// - encoder type change applies only after power cycle
// - divider independent of electronic gear settings
package enc_div_pkg;
	// ---------------------------------------------------------------
	// encoder and divider constants
	// ---------------------------------------------------------------
	localparam logic [11:0] INCR_PPR      = 12'h800;
	localparam logic [11:0] ABS_PPR       = 12'h400;
	localparam logic [11:0] RATIO_MIN     = 12'h010;
	localparam logic [11:0] RATIO_DEFAULT = 12'h800;
	localparam int          ERR_W         = 24;

	// quadrature state of one channel pair
	typedef struct packed {
		logic a;
		logic b;
	} quad_s;

	// differential output pair
	typedef struct packed {
		logic p;
		logic n;
	} diff_s;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LIVE = 2'b01
	} boot_e;
endpackage

// ---- rtl/quad_step.sv ----
// quadrature decoder: one-cycle step and direction from a/b pair
`timescale 1ns/1ps
module quad_step (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                arst_n,
	// encoder phases
	input  wire enc_div_pkg::quad_s  enc_in,
	// decoded step
	output logic                     step,
	output logic                     dir_up
);
	import enc_div_pkg::*;

	quad_s prev_q;
	quad_s prev_d;
	logic  step_d;
	logic  up_d;
	logic  step_q;
	logic  up_q;
	logic  primed_q;
	logic  primed_d;

	// gray transitions give one step; a leading b means counting up
	// no step on the first edge after reset: the encoder may rest anywhere
	always_comb begin
		prev_d   = enc_in;
		primed_d = 1'b1;
		step_d   = primed_q & ((enc_in.a ^ prev_q.a) ^ (enc_in.b ^ prev_q.b));
		up_d   = enc_in.a ^ prev_q.b;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prev_q   <= '0;
			step_q   <= 1'b0;
			up_q     <= 1'b0;
			primed_q <= 1'b0;
		end else begin
			primed_q <= primed_d;
			prev_q <= prev_d;
			step_q <= step_d;
			up_q   <= up_d;
		end
	end

	assign step   = step_q;
	assign dir_up = up_q;
endmodule

// ---- rtl/error_clear_encoder_divider.sv ----
// error counter clear logic and encoder pulse divider with a/b/c outputs
`timescale 1ns/1ps
module error_clear_encoder_divider (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                arst_n,
	// host clear input and mode
	input  wire logic                error_count_clear_in,
	input  wire logic                clear_mode_switch,
	// reference and feedback pulses for the error counter
	input  wire logic                ref_pulse,
	input  wire logic                ref_dir_up,
	// motor encoder
	input  wire enc_div_pkg::quad_s  motor_encoder,
	input  wire logic                motor_index,
	// settings
	input  wire logic                encoder_type_switch,
	input  wire logic [11:0]         divider_ratio_param,
	input  wire logic                factory_reset,
	// error counter and loop status
	output logic [enc_div_pkg::ERR_W-1:0] error_count,
	output logic                     loop_enable,
	// divided outputs
	output enc_div_pkg::diff_s       div_phase_a_out,
	output enc_div_pkg::diff_s       div_phase_b_out,
	output enc_div_pkg::diff_s       div_index_out,
	// active settings
	output logic                     enc_type_active,
	output logic [11:0]              output_pulses_per_rev
);
	import enc_div_pkg::*;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// clamp the ratio to the range allowed by the encoder type
	function automatic logic [11:0] clamp_ratio(input logic [11:0] r, input logic abs_t);
		logic [11:0] top;
		top = abs_t ? ABS_PPR : INCR_PPR;
		if (r < RATIO_MIN)
			return RATIO_MIN;
		else if (r > top)
			return top;
		return r;
	endfunction

	function automatic diff_s to_diff(input logic v);
		to_diff = '{p: v, n: ~v};
	endfunction

	// ---------------------------------------------------------------
	// encoder type latch and ratio parameter
	// ---------------------------------------------------------------
	boot_e       boot_q;
	boot_e       boot_d;
	logic        type_q;
	logic        type_d;
	logic [11:0] ratio_q;
	logic [11:0] ratio_d;

	// type is caught once after reset release, so later writes wait for power cycle
	always_comb begin
		boot_d  = boot_q;
		type_d  = type_q;
		ratio_d = clamp_ratio(divider_ratio_param, type_q);
		case (boot_q)
			ST_IDLE: begin
				type_d = encoder_type_switch;
				boot_d = ST_LIVE;
			end
			ST_LIVE: type_d = type_q;
			default: boot_d = ST_IDLE;
		endcase
		// default still obeys the ceiling of an absolute encoder
		if (factory_reset)
			ratio_d = clamp_ratio(RATIO_DEFAULT, type_q);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			boot_q  <= ST_IDLE;
			type_q  <= 1'b0;
			ratio_q <= RATIO_DEFAULT;
		end else begin
			boot_q  <= boot_d;
			type_q  <= type_d;
			ratio_q <= ratio_d;
		end
	end

	// ---------------------------------------------------------------
	// motor encoder decode
	// ---------------------------------------------------------------
	logic enc_step;
	logic enc_up;

	quad_step u_quad (
		.clk    (clk),
		.arst_n (arst_n),
		.enc_in (motor_encoder),
		.step   (enc_step),
		.dir_up (enc_up)
	);

	// ---------------------------------------------------------------
	// error counter with clear modes
	// ---------------------------------------------------------------
	logic             clr_prev_q;
	logic             clr_prev_d;
	logic [ERR_W-1:0] err_q;
	logic [ERR_W-1:0] err_d;
	logic             loop_q;
	logic             loop_d;
	logic             clr_now;

	// the clear path ignores the gear settings entirely; feedback is raw
	always_comb begin
		clr_prev_d = error_count_clear_in;
		err_d      = err_q;
		if (ref_pulse)
			err_d = ref_dir_up ? err_d + 1'b1 : err_d - 1'b1;
		if (enc_step)
			err_d = enc_up ? err_d - 1'b1 : err_d + 1'b1;
		clr_now = clear_mode_switch
			? (error_count_clear_in & ~clr_prev_q)
			: error_count_clear_in;
		if (clr_now)
			err_d = '0;
		loop_d = ~error_count_clear_in;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			clr_prev_q <= 1'b0;
			err_q      <= '0;
			loop_q     <= 1'b0;
		end else begin
			clr_prev_q <= clr_prev_d;
			err_q      <= err_d;
			loop_q     <= loop_d;
		end
	end

	// ---------------------------------------------------------------
	// pulse divider: rate accumulator, independent of electronic gear
	// ---------------------------------------------------------------
	logic [12:0] acc_q;
	logic [12:0] acc_d;
	logic [1:0]  phase_q;
	logic [1:0]  phase_d;
	logic [12:0] rev_q;
	logic [12:0] rev_d;
	logic [12:0] rev_last;
	logic        idx_q;
	logic        idx_d;
	logic [12:0] ppr_w;

	// each up step adds ratio, each down step subtracts it; leaving 0..ppr-1 makes one output step
	always_comb begin
		ppr_w   = {1'b0, (type_q ? ABS_PPR : INCR_PPR)};
		// four quadrature steps per encoder pulse make one revolution
		rev_last = {ppr_w[10:0] - 11'h001, 2'b11};
		acc_d   = acc_q;
		phase_d = phase_q;
		rev_d   = rev_q;
		idx_d   = idx_q;
		if (enc_step) begin
			if (enc_up) begin
				acc_d = acc_q + {1'b0, ratio_q};
				rev_d = (rev_q == rev_last) ? 13'h0 : rev_q + 13'h1;
			end else begin
				acc_d = acc_q - {1'b0, ratio_q};
				rev_d = (rev_q == 13'h0) ? rev_last : rev_q - 13'h1;
			end
			if (enc_up && acc_d >= ppr_w) begin
				acc_d   = acc_d - ppr_w;
				phase_d = phase_q + 2'h1;
			end else if (!enc_up && acc_d[12]) begin
				acc_d   = acc_d + ppr_w;
				phase_d = phase_q - 2'h1;
			end
		end
		if (motor_index)
			rev_d = 13'h0;
		idx_d = (rev_d == 13'h0);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_q   <= '0;
			phase_q <= 2'h0;
			rev_q   <= 13'h0;
			idx_q   <= 1'b0;
		end else begin
			acc_q   <= acc_d;
			phase_q <= phase_d;
			rev_q   <= rev_d;
			idx_q   <= idx_d;
		end
	end

	// ---------------------------------------------------------------
	// registered outputs
	// ---------------------------------------------------------------
	diff_s a_q;
	diff_s b_q;
	diff_s c_q;
	diff_s a_d;
	diff_s b_d;
	diff_s c_d;

	// gray sequence of phase counter: 00,01,11,10 gives a leading b
	always_comb begin
		a_d = to_diff(phase_d[1] ^ phase_d[0]);
		b_d = to_diff(phase_d[1]);
		c_d = to_diff(idx_d);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			a_q <= '{p: 1'b0, n: 1'b1};
			b_q <= '{p: 1'b0, n: 1'b1};
			c_q <= '{p: 1'b0, n: 1'b1};
		end else begin
			a_q <= a_d;
			b_q <= b_d;
			c_q <= c_d;
		end
	end

	assign div_phase_a_out       = a_q;
	assign div_phase_b_out       = b_q;
	assign div_index_out         = c_q;
	assign error_count           = err_q;
	assign loop_enable           = loop_q;
	assign enc_type_active       = type_q;
	assign output_pulses_per_rev = ratio_q;
endmodule

// ---- sim/enc_div_properties.sv ----
// concurrent checks on clear logic and divider outputs
`timescale 1ns/1ps
module enc_div_properties (
	// clock and reset
	input wire logic				clk,
	input wire logic				arst_n,
	// clear and settings
	input wire logic				error_count_clear_in,
	input wire logic				clear_mode_switch,
	input wire logic				factory_reset,
	input wire logic [11:0]			divider_ratio_param,
	// observed outputs
	input wire logic [enc_div_pkg::ERR_W-1:0]	error_count,
	input wire logic				loop_enable,
	input wire enc_div_pkg::diff_s		div_phase_a_out,
	input wire enc_div_pkg::diff_s		div_phase_b_out,
	input wire enc_div_pkg::diff_s		div_index_out,
	input wire logic				enc_type_active,
	input wire logic [11:0]			output_pulses_per_rev
);
	import enc_div_pkg::*;
	logic [11:0] top;
	// ----
	// ratio ceiling for the latched encoder type
	// ----
	assign top = enc_type_active ? ABS_PPR : INCR_PPR;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	property p_loop; 1 |=> loop_enable == !$past(error_count_clear_in); endproperty
	a_loop: assert property (p_loop) else $error("loop enable wrong");
	property p_level; !clear_mode_switch && error_count_clear_in |=> error_count == '0; endproperty
	a_level: assert property (p_level) else $error("level clear missed");
	property p_edge; clear_mode_switch && $rose(error_count_clear_in) |=> error_count == '0;
	endproperty
	a_edge: assert property (p_edge) else $error("edge clear missed");
	property p_diff; div_phase_a_out.n != div_phase_a_out.p && div_phase_b_out.n !=
		div_phase_b_out.p && div_index_out.n != div_index_out.p; endproperty
	a_diff: assert property (p_diff) else $error("pair not complementary");
	property p_range; output_pulses_per_rev >= RATIO_MIN &&
		output_pulses_per_rev <= ($past(enc_type_active) ? ABS_PPR : INCR_PPR); endproperty
	a_range: assert property (p_range) else $error("ratio out of range");
	property p_apply; $past(arst_n) && !factory_reset && divider_ratio_param >= RATIO_MIN &&
		divider_ratio_param <= top |=> output_pulses_per_rev == $past(divider_ratio_param);
	endproperty
	a_apply: assert property (p_apply) else $error("ratio not applied");
	property p_dflt; $past(arst_n) && factory_reset && !enc_type_active |=>
		output_pulses_per_rev == RATIO_DEFAULT; endproperty
	a_dflt: assert property (p_dflt) else $error("default ratio wrong");
	property p_type; $changed(enc_type_active) |-> !$past(arst_n, 2); endproperty
	a_type: assert property (p_type) else $error("type changed live");
	property p_quad; !($changed(div_phase_a_out.p) && $changed(div_phase_b_out.p)); endproperty
	a_quad: assert property (p_quad) else $error("a and b moved together");
endmodule

// ---- sim/host_ctrl_model.sv ----
// host controller model counting divided quadrature steps
`timescale 1ns/1ps
module host_ctrl_model (
	// clock and reset
	input wire logic		clk,
	input wire logic		arst_n,
	// divided phases from the drive
	input wire enc_div_pkg::diff_s	pa,
	input wire enc_div_pkg::diff_s	pb,
	// counted steps
	output logic [15:0]		steps
);
	import enc_div_pkg::*;
	logic pa_q, pb_q;
	// every edge on either receiver is one step; direction is not needed here
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			{pa_q, pb_q, steps} <= '0;
		end else begin
			{pa_q, pb_q} <= {pa.p, pb.p};
			steps <= steps + 16'(pa.p ^ pa_q) + 16'(pb.p ^ pb_q);
		end
	end
endmodule

// ---- sim/testbench.sv ----
// bench for clear logic and encoder divider with host model
`timescale 1ns/1ps
module testbench;
	import enc_div_pkg::*;
	logic			clk, arst_n, error_count_clear_in, clear_mode_switch, ref_pulse;
	logic			encoder_type_switch, factory_reset, loop_enable, enc_type_active;
	logic			motor_index, idx_prev;
	logic [15:0]		idx_rises;
	logic [11:0]		divider_ratio_param, output_pulses_per_rev;
	logic [ERR_W-1:0]	error_count;
	logic [1:0]		ph;
	logic [15:0]		steps;
	logic [31:0]		seed;
	quad_s			motor_encoder;
	diff_s			div_phase_a_out, div_phase_b_out, div_index_out;
	int			n_errors, checks_done, cycles;
	// encoder walks the gray sequence one step at a time
	assign motor_encoder = '{a: ph[1], b: ph[1] ^ ph[0]};
	error_clear_encoder_divider DUT (.clk, .arst_n, .error_count_clear_in,
		.clear_mode_switch, .ref_pulse, .ref_dir_up(1'b1), .motor_encoder,
		.motor_index, .encoder_type_switch, .divider_ratio_param, .factory_reset,
		.error_count, .loop_enable, .div_phase_a_out, .div_phase_b_out, .div_index_out,
		.enc_type_active, .output_pulses_per_rev);
	host_ctrl_model host (.clk, .arst_n, .pa(div_phase_a_out), .pb(div_phase_b_out), .steps);
	// ----
	// helpers
	// ----
	task automatic chk(input logic [23:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// expected active ratio: requested value held inside 16..encoder pulses
	function automatic logic [11:0] exp_ratio(input logic [11:0] r, input logic abs_t);
		logic [11:0] top;
		top = abs_t ? ABS_PPR : INCR_PPR;
		return (r < RATIO_MIN) ? RATIO_MIN : ((r > top) ? top : r);
	endfunction
	// index rising edges seen by the host
	always @(posedge clk) begin
		idx_prev <= div_index_out.p;
		if (div_index_out.p && !idx_prev) idx_rises <= idx_rises + 16'h1;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic finish_test;
		if (n_errors == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic do_reset;
		arst_n <= 0;
		@(posedge clk);
		#1 chk({div_index_out, div_phase_b_out, div_phase_a_out}, 6'h15);
		chk(output_pulses_per_rev, RATIO_DEFAULT);
		@(posedge clk) arst_n <= 1;
	endtask
	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge clk) ref_pulse <= 1;
			@(posedge clk) ref_pulse <= 0;
		end
	endtask
	// n motor steps, a quarter revolution in every call here; host counts divided steps
	task automatic rev(input logic [11:0] r, e, input int n);
		logic [15:0] s0;
		@(posedge clk) divider_ratio_param <= r;
		repeat (3) @(posedge clk);
		#1 chk(output_pulses_per_rev, e);
		s0 = steps;
		repeat (n) begin
			@(posedge clk) ph <= ph + 2'h1;
			@(posedge clk);
		end
		repeat (4) @(posedge clk);
		#1 chk(steps - s0, e);
	endtask
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	// hang guard, ceiling well above the planned run
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			n_errors++;
			finish_test;
		end
	end
	initial begin
		logic [4:0] k;
		logic [15:0] i0, s1;
		{arst_n, error_count_clear_in, clear_mode_switch, ref_pulse, ph} = '0;
		{encoder_type_switch, factory_reset, n_errors, checks_done, cycles} = '0;
		{motor_index, idx_prev, idx_rises} = '0;
		divider_ratio_param = 12'h800;
		seed = 32'hbab8;
		do_reset;
		seed = lfsr(seed);
		k = 5'(seed[3:0]) + 5'h1;
		pulses(k);
		#1 chk(error_count, 24'(k));
		@(posedge clk) error_count_clear_in <= 1;
		pulses(3);
		#1 chk(error_count, 24'h0);
		chk(loop_enable, 24'h0);
		@(posedge clk);
		clear_mode_switch <= 1;
		error_count_clear_in <= 0;
		pulses(3);
		@(posedge clk) error_count_clear_in <= 1;
		pulses(k);
		#1 chk(error_count, 24'(k));
		chk(loop_enable, 24'h0);
		@(posedge clk) error_count_clear_in <= 0;
		seed = lfsr(seed);
		rev(12'h010, exp_ratio(12'h010, 1'b0), 2048);
		rev(12'h800, exp_ratio(12'h800, 1'b0), 2048);
		rev({1'b0, seed[10:0]} | 12'h010, exp_ratio({1'b0, seed[10:0]} | 12'h010, 1'b0),
			2048);
		rev(12'h005, exp_ratio(12'h005, 1'b0), 2048);
		@(posedge clk);
		factory_reset <= 1;
		divider_ratio_param <= 12'h123;
		repeat (2) @(posedge clk);
		#1 chk(output_pulses_per_rev, 12'h800);
		@(posedge clk);
		factory_reset <= 0;
		encoder_type_switch <= 1;
		repeat (3) @(posedge clk);
		#1 chk(enc_type_active, 24'h0);
		@(posedge clk);
		do_reset;
		repeat (2) @(posedge clk);
		#1 chk(enc_type_active, 24'h1);
		rev(12'h800, exp_ratio(12'h800, 1'b1), 1024);
		// index mark forced by the motor index, then one mark per revolution
		@(posedge clk) motor_index <= 1;
		@(posedge clk) motor_index <= 0;
		#1 chk(div_index_out, 24'h2);
		@(posedge clk);
		#1 {i0, s1} = {idx_rises, steps};
		// reverse direction, one quadrature step per cycle, 4096 steps per rev
		repeat (4096) @(posedge clk) ph <= ph - 2'h1;
		repeat (4) @(posedge clk);
		#1 chk(idx_rises - i0, 24'h1);
		chk(steps - s1, 24'h1000);
		finish_test;
	end
endmodule
bind error_clear_encoder_divider enc_div_properties u_props (.clk, .arst_n,
	.error_count_clear_in, .clear_mode_switch, .factory_reset, .divider_ratio_param,
	.error_count, .loop_enable, .div_phase_a_out, .div_phase_b_out, .div_index_out,
	.enc_type_active, .output_pulses_per_rev);
